/* hw/pmrc_top.v */
// operating mode, debug stop and restart controller
// assumes one scan_start pulse per scan and a step engine that waits
// for step_go before running each presented step
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "pmrc_regs.vh"
module pmrc_top (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [31:0] reg_rdata,
	// front switch and scan timebase
	input wire [1:0] sw_pos,
	input wire scan_start,
	// remote requests
	input wire req_valid,
	input wire [1:0] req_src,
	input wire [1:0] req_mode,
	input wire cmd_reset,
	input wire cmd_overall_reset,
	// stop functions called by the program
	input wire stop_function,
	input wire emergency_halt_function,
	// program engine
	input wire step_valid,
	input wire [15:0] step_addr,
	input wire step_done,
	input wire acc_valid,
	input wire acc_write,
	input wire [15:0] acc_addr,
	input wire [15:0] acc_data,
	// restart conditions
	input wire program_changed,
	input wire download_stop,
	input wire error_stop,
	input wire retain_invalid,
	// mode and execution control
	output wire [1:0] mode,
	output wire step_go,
	output wire debug_halted,
	output wire [7:0] task_run,
	// data initialisation
	output wire init_start,
	output wire init_cold,
	output wire keep_retain
);
	reg [1:0] mode_reg;
	reg [1:0] mode_next;
	reg [1:0] last_pos_reg;
	reg from_stop_reg;
	reg stop_pend_reg;
	reg req_pend_reg;
	reg [1:0] req_src_reg;
	reg [1:0] req_mode_reg;
	reg rst_pend_reg;
	reg ovr_pend_reg;
	reg reject_reg;
	reg [7:0] ctrl_reg;
	reg [15:0] scan_target_reg;
	reg [15:0] watch_addr_reg;
	reg [15:0] watch_val_reg;
	reg [1:0] watch_cond_reg;
	reg [7:0] task_en_reg;
	reg halted_reg;
	reg step_used_reg;
	reg skip_bp_reg;
	reg [15:0] scans_reg;
	reg step_go_reg;
	reg [7:0] task_run_reg;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;
	reg accept;
	reg reject;
	wire [`PMRC_BP_COUNT-1:0] bp_hit_vec;
	wire [31:0] bp_entry [0:`PMRC_BP_COUNT-1];
	wire in_dbg;
	wire running;
	wire sw_moved;
	wire remote_ok;
	wire src_ok;
	wire trans_ok;
	wire run_cmd;
	wire bp_hit;
	wire watch_hit;
	wire scan_hit;
	wire halt_set;
	wire go;
	wire enter_init;
	wire do_init;
	wire [15:0] scans_inc;

	// mode change permitted over the remote path
	function allowed;
		input [1:0] cur;
		input [1:0] tgt;
		begin
			case ({cur, tgt})
			{`PMRC_M_STOP, `PMRC_M_RUN}: allowed = 1'b1;
			{`PMRC_M_STOP, `PMRC_M_DEBUG}: allowed = 1'b1;
			{`PMRC_M_RUN, `PMRC_M_PAUSE}: allowed = 1'b1;
			{`PMRC_M_RUN, `PMRC_M_STOP}: allowed = 1'b1;
			{`PMRC_M_PAUSE, `PMRC_M_RUN}: allowed = 1'b1;
			{`PMRC_M_PAUSE, `PMRC_M_STOP}: allowed = 1'b1;
			{`PMRC_M_DEBUG, `PMRC_M_STOP}: allowed = 1'b1;
			default: allowed = 1'b0;
			endcase
		end
	endfunction

	assign in_dbg = (mode_reg == `PMRC_M_DEBUG);
	assign running = (mode_reg == `PMRC_M_RUN) | (in_dbg & ~halted_reg);
	assign sw_moved = (sw_pos != last_pos_reg);
	assign remote_ok = (last_pos_reg == `PMRC_SW_REM) & from_stop_reg;
	assign src_ok = ctrl_reg[`PMRC_CTRL_COMM] |
		(req_src_reg == `PMRC_SRC_LOCAL) |
		(req_src_reg == `PMRC_SRC_NETTOOL);
	assign trans_ok = allowed(mode_reg, req_mode_reg);
	assign run_cmd = reg_wr & (reg_addr == `PMRC_DBG_CMD_OFS) & reg_wdata[0];

	// next mode, evaluated only at the start of a scan
	always @* begin
		mode_next = mode_reg;
		accept = 1'b0;
		reject = 1'b0;
		if (scan_start) begin
			if (stop_pend_reg)
				mode_next = `PMRC_M_STOP;
			else if (sw_moved) begin
				case (sw_pos)
				`PMRC_SW_RUN: mode_next = `PMRC_M_RUN;
				`PMRC_SW_STOP: mode_next = `PMRC_M_STOP;
				`PMRC_SW_REM: begin
					if (last_pos_reg == `PMRC_SW_STOP)
						mode_next = `PMRC_M_STOP;
					else if (mode_reg == `PMRC_M_RUN &&
						ctrl_reg[`PMRC_CTRL_LPAUSE])
						mode_next = `PMRC_M_PAUSE;
				end
				default: mode_next = mode_reg;
				endcase
				if (req_pend_reg)
					reject = 1'b1;
			end else if (req_pend_reg) begin
				if (remote_ok && src_ok && trans_ok) begin
					mode_next = req_mode_reg;
					accept = 1'b1;
				end else
					reject = 1'b1;
			end
		end
	end

	// mode, switch history and pending requests
	always @(posedge clk) begin
		if (!rst_n) begin
			mode_reg <= `PMRC_M_STOP;
			last_pos_reg <= `PMRC_SW_STOP;
			from_stop_reg <= 1'b0;
			stop_pend_reg <= 1'b0;
			req_pend_reg <= 1'b0;
			req_src_reg <= `PMRC_SRC_LOCAL;
			req_mode_reg <= `PMRC_M_STOP;
			rst_pend_reg <= 1'b0;
			ovr_pend_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			if (scan_start) begin
				last_pos_reg <= sw_pos;
				if (sw_moved)
					from_stop_reg <= (last_pos_reg == `PMRC_SW_STOP);
			end
			// a request arriving at the evaluating scan waits for the next
			if (stop_function | emergency_halt_function)
				stop_pend_reg <= 1'b1;
			else if (scan_start)
				stop_pend_reg <= 1'b0;
			if (req_valid) begin
				req_pend_reg <= 1'b1;
				req_src_reg <= req_src;
				req_mode_reg <= req_mode;
			end else if (scan_start)
				req_pend_reg <= 1'b0;
			if (cmd_reset | cmd_overall_reset)
				rst_pend_reg <= 1'b1;
			else if (scan_start)
				rst_pend_reg <= 1'b0;
			if (cmd_overall_reset)
				ovr_pend_reg <= 1'b1;
			else if (scan_start)
				ovr_pend_reg <= 1'b0;
		end
	end

	// breakpoint store
	genvar i;
	generate
		for (i = 0; i < `PMRC_BP_COUNT; i = i + 1) begin : g_bp
			pmrc_bp_cell u_bp (
				.clk(clk),
				.rst_n(rst_n),
				.wr(reg_wr &&
					{24'h000000, reg_addr} == (`PMRC_BP_BASE_OFS + i * 4)),
				.wdata(reg_wdata),
				.step_addr(step_addr),
				.entry(bp_entry[i]),
				.hit(bp_hit_vec[i])
			);
		end
	endgenerate

	// debug stop conditions, any combination at once
	assign bp_hit = ctrl_reg[`PMRC_CTRL_BP] & step_valid & ~skip_bp_reg &
		(|bp_hit_vec);
	assign watch_hit = ctrl_reg[`PMRC_CTRL_WATCH] & acc_valid &
		(acc_addr == watch_addr_reg) &
		(((watch_cond_reg == `PMRC_W_READ) & ~acc_write) |
		((watch_cond_reg == `PMRC_W_WRITE) & acc_write) |
		((watch_cond_reg == `PMRC_W_VALUE) &
		(acc_data == watch_val_reg)));
	assign scans_inc = scans_reg + 16'h0001;
	assign scan_hit = ctrl_reg[`PMRC_CTRL_SCAN] & scan_start &
		(scans_inc >= scan_target_reg);
	assign halt_set = in_dbg & ~halted_reg & (bp_hit | watch_hit | scan_hit |
		(ctrl_reg[`PMRC_CTRL_STEP] & step_done));
	assign go = step_valid & running & ~bp_hit & ~step_go_reg &
		~(in_dbg & ctrl_reg[`PMRC_CTRL_STEP] & step_used_reg);

	always @(posedge clk) begin
		if (!rst_n) begin
			halted_reg <= 1'b0;
			step_used_reg <= 1'b0;
			skip_bp_reg <= 1'b0;
			scans_reg <= 16'h0000;
			step_go_reg <= 1'b0;
			task_run_reg <= 8'h00;
		end else begin
			// debug entry waits halted for the first run command
			if (mode_next == `PMRC_M_DEBUG && !in_dbg)
				halted_reg <= 1'b1;
			else if (!in_dbg)
				halted_reg <= 1'b0;
			else if (halt_set)
				halted_reg <= 1'b1;
			else if (run_cmd)
				halted_reg <= 1'b0;
			if (run_cmd)
				step_used_reg <= 1'b0;
			else if (go)
				step_used_reg <= 1'b1;
			// resume past the breakpoint only at a step already waiting
			if (run_cmd)
				skip_bp_reg <= step_valid;
			else if (go)
				skip_bp_reg <= 1'b0;
			if (run_cmd || !in_dbg)
				scans_reg <= 16'h0000;
			else if (scan_start && !halted_reg)
				scans_reg <= scans_inc;
			step_go_reg <= go;
			if (mode_reg == `PMRC_M_RUN)
				task_run_reg <= 8'hFF;
			else if (in_dbg && !halted_reg)
				task_run_reg <= task_en_reg;
			else
				task_run_reg <= 8'h00;
		end
	end

	// restart on entry to run or debug from stop, or on reset commands
	assign enter_init = scan_start & (mode_reg == `PMRC_M_STOP) &
		((mode_next == `PMRC_M_RUN) | (mode_next == `PMRC_M_DEBUG));
	assign do_init = enter_init | (scan_start & rst_pend_reg);

	pmrc_restart u_restart (
		.clk(clk),
		.rst_n(rst_n),
		.do_init(do_init),
		.cfg_warm(ctrl_reg[`PMRC_CTRL_WARM]),
		.cold_cmd(ovr_pend_reg),
		.program_changed(program_changed),
		.stop_cold_cause(download_stop | error_stop),
		.retain_invalid(retain_invalid),
		.init_start(init_start),
		.init_cold(init_cold),
		.keep_retain(keep_retain)
	);

	// software registers
	always @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= `PMRC_CTRL_RST;
			scan_target_reg <= 16'h0000;
			watch_addr_reg <= 16'h0000;
			watch_val_reg <= 16'h0000;
			watch_cond_reg <= `PMRC_W_READ;
			task_en_reg <= `PMRC_TASK_EN_RST;
			reject_reg <= 1'b0;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
				`PMRC_CTRL_OFS: ctrl_reg <= reg_wdata[7:0];
				`PMRC_SCAN_CNT_OFS: scan_target_reg <= reg_wdata[15:0];
				`PMRC_WATCH_ADDR_OFS: watch_addr_reg <= reg_wdata[15:0];
				`PMRC_WATCH_CFG_OFS: begin
					watch_val_reg <= reg_wdata[15:0];
					watch_cond_reg <= reg_wdata[17:16];
				end
				`PMRC_TASK_EN_OFS: task_en_reg <= reg_wdata[7:0];
				default: ctrl_reg <= ctrl_reg;
				endcase
			end
			// a new refusal wins over a clear in the same cycle
			if (reject)
				reject_reg <= 1'b1;
			else if (reg_wr && reg_addr == `PMRC_STATUS_OFS &&
				reg_wdata[`PMRC_ST_REJECT])
				reject_reg <= 1'b0;
		end
	end

	integer k;
	always @* begin
		rdata_next = 32'h00000000;
		case (reg_addr)
		`PMRC_CTRL_OFS: rdata_next = {24'h000000, ctrl_reg};
		`PMRC_SCAN_CNT_OFS: rdata_next = {16'h0000, scan_target_reg};
		`PMRC_WATCH_ADDR_OFS: rdata_next = {16'h0000, watch_addr_reg};
		`PMRC_WATCH_CFG_OFS:
			rdata_next = {14'h0000, watch_cond_reg, watch_val_reg};
		`PMRC_TASK_EN_OFS: rdata_next = {24'h000000, task_en_reg};
		`PMRC_STATUS_OFS:
			rdata_next = {scans_reg, 7'h00, reject_reg, 3'h0, init_cold,
				remote_ok, halted_reg, mode_reg};
		default: begin
			for (k = 0; k < `PMRC_BP_COUNT; k = k + 1)
				if ({24'h000000, reg_addr} == `PMRC_BP_BASE_OFS + k * 4)
					rdata_next = bp_entry[k];
		end
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n)
			rdata_reg <= 32'h00000000;
		else if (reg_rd)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= 32'h00000000;
	end

	assign reg_rdata = rdata_reg;
	assign mode = mode_reg;
	assign step_go = step_go_reg;
	assign debug_halted = halted_reg;
	assign task_run = task_run_reg;
endmodule // pmrc_top

/* hw/pmrc_regs.vh */
// constants for the mode and restart controller: offsets, fields, codes
// assumes byte addresses on an 8-bit register port with 32-bit data
`ifndef PMRC_REGS_VH
`define PMRC_REGS_VH
// register byte offsets
`define PMRC_CTRL_OFS 8'h00
`define PMRC_DBG_CMD_OFS 8'h04
`define PMRC_SCAN_CNT_OFS 8'h08
`define PMRC_WATCH_ADDR_OFS 8'h0C
`define PMRC_WATCH_CFG_OFS 8'h10
`define PMRC_TASK_EN_OFS 8'h14
`define PMRC_STATUS_OFS 8'h18
`define PMRC_BP_BASE_OFS 8'h20
// control fields
`define PMRC_CTRL_WARM 0
`define PMRC_CTRL_LPAUSE 1
`define PMRC_CTRL_COMM 2
`define PMRC_CTRL_STEP 4
`define PMRC_CTRL_BP 5
`define PMRC_CTRL_WATCH 6
`define PMRC_CTRL_SCAN 7
`define PMRC_CTRL_RST 8'h00
`define PMRC_TASK_EN_RST 8'hFF
// status fields
`define PMRC_ST_HALT 2
`define PMRC_ST_REMOTE 3
`define PMRC_ST_COLD 4
`define PMRC_ST_REJECT 8
// breakpoint entry valid bit and number of entries
`define PMRC_BP_VALID 31
`define PMRC_BP_COUNT 8
// modes
`define PMRC_M_STOP 2'h0
`define PMRC_M_RUN 2'h1
`define PMRC_M_PAUSE 2'h2
`define PMRC_M_DEBUG 2'h3
// switch positions
`define PMRC_SW_STOP 2'h0
`define PMRC_SW_REM 2'h1
`define PMRC_SW_RUN 2'h2
// request sources
`define PMRC_SRC_LOCAL 2'h0
`define PMRC_SRC_NETTOOL 2'h1
`define PMRC_SRC_LINK 2'h2
`define PMRC_SRC_NETCMD 2'h3
// watch conditions
`define PMRC_W_READ 2'h0
`define PMRC_W_WRITE 2'h1
`define PMRC_W_VALUE 2'h2
`endif

/* hw/pmrc_bp_cell.v */
// one breakpoint location with its address compare
// assumes register writes are decoded by the parent
`timescale 1ns/10ps
`include "pmrc_regs.vh"
module pmrc_bp_cell (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// write port
	input wire wr,
	input wire [31:0] wdata,
	// compare
	input wire [15:0] step_addr,
	output wire [31:0] entry,
	output wire hit
);
	reg [31:0] entry_reg;
	always @(posedge clk) begin
		if (!rst_n)
			entry_reg <= 32'h00000000;
		else if (wr)
			entry_reg <= {wdata[`PMRC_BP_VALID], 15'h0000, wdata[15:0]};
	end
	assign entry = entry_reg;
	assign hit = entry_reg[`PMRC_BP_VALID] & (entry_reg[15:0] == step_addr);
endmodule // pmrc_bp_cell

/* hw/pmrc_restart.v */
// restart type decision and data initialisation request
// assumes do_init is a one-cycle pulse at a scan that enters run or debug from stop or carries a reset command
`timescale 1ns/10ps
`include "pmrc_regs.vh"
module pmrc_restart (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// triggers and conditions
	input wire do_init,
	input wire cfg_warm,
	input wire cold_cmd,
	input wire program_changed,
	input wire stop_cold_cause,
	input wire retain_invalid,
	// initialisation request
	output wire init_start,
	output wire init_cold,
	output wire keep_retain
);
	reg force_reg;
	reg force_next;
	reg start_reg;
	reg cold_reg;
	reg keep_reg;
	wire cold;
	assign cold = ~cfg_warm | force_reg | retain_invalid | cold_cmd;
	always @* begin
		force_next = force_reg;
		if (do_init)
			force_next = 1'b0;
		if (program_changed)
			force_next = 1'b1;
		if (stop_cold_cause)
			force_next = 1'b1;
	end
	always @(posedge clk) begin
		if (!rst_n) begin
			force_reg <= 1'b0;
			start_reg <= 1'b0;
			cold_reg <= 1'b0;
			keep_reg <= 1'b0;
		end else begin
			force_reg <= force_next;
			start_reg <= do_init;
			if (do_init) begin
				cold_reg <= cold;
				keep_reg <= ~cold;
			end
		end
	end
	assign init_start = start_reg;
	assign init_cold = cold_reg;
	assign keep_retain = keep_reg;
endmodule // pmrc_restart

/* verification/pmrc_sva.sv */
// port checks for the mode and restart controller
// assumes it is bound to pmrc_top, one clock domain
`timescale 1ns/10ps
`include "pmrc_regs.vh"
module pmrc_sva (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// watched ports
	input wire scan_start,
	input wire stop_function,
	input wire emergency_halt_function,
	input wire [1:0] mode,
	input wire step_go,
	input wire debug_halted,
	input wire [7:0] task_run,
	input wire init_start,
	input wire init_cold,
	input wire keep_retain
);
	logic pend_reg = 1'b0;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a stop call waits for the next scan, not one in the same cycle
	always @(posedge clk) begin
		pend_reg <= rst_n & ((pend_reg & ~scan_start) | stop_function |
			emergency_halt_function);
	end
	a_mode_scan_only: assert property (!scan_start |=> $stable(mode))
		else $error("mode changed outside a scan");
	a_stop_call: assert property (scan_start && pend_reg |=>
		mode == `PMRC_M_STOP) else $error("stop call not applied");
	a_debug_entry: assert property (mode == `PMRC_M_RUN ||
		mode == `PMRC_M_PAUSE |=> mode != `PMRC_M_DEBUG)
		else $error("debug entered from run or pause");
	a_go_spacing: assert property (step_go |=> !step_go)
		else $error("step permission in consecutive cycles");
	a_halt_blocks: assert property (debug_halted &&
		$past(debug_halted) |-> !step_go) else $error("step while halted");
	a_init_scan: assert property (init_start |-> $past(scan_start))
		else $error("initialisation outside a scan");
	a_init_single: assert property (init_start |=> (!init_start)[*8])
		else $error("initialisation repeated");
	a_retain_kind: assert property (init_start |->
		keep_retain == !init_cold) else $error("retain keep wrong");
	a_run_init: assert property ($rose(mode == `PMRC_M_RUN) &&
		$past(mode) == `PMRC_M_STOP |-> init_start)
		else $error("no initialisation on run entry");
	a_run_tasks: assert property (mode == `PMRC_M_RUN &&
		$past(mode) == `PMRC_M_RUN |-> task_run == 8'hFF)
		else $error("tasks not all running");
	a_stop_idle: assert property (mode == `PMRC_M_STOP &&
		$past(mode) == `PMRC_M_STOP |-> task_run == 8'h00 && !step_go)
		else $error("execution while stopped");
endmodule // pmrc_sva

/* verification/pmrc_src.sv */
// model of the mode switch and the remote command sources
// assumes the bench calls its tasks right after a rising edge
`timescale 1ns/10ps
module pmrc_src (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// switch, scan timebase, requests
	output logic [1:0] sw_pos = 2'h0,
	output logic scan_start = 1'b0,
	output logic req_valid = 1'b0,
	output logic [1:0] req_src = 2'h0,
	output logic [1:0] req_mode = 2'h0
);
	logic [3:0] div_reg = 4'h0;
	// one scan every 16 cycles
	always @(posedge clk) begin
		div_reg <= rst_n ? div_reg + 4'h1 : 4'h0;
		scan_start <= rst_n && div_reg == 4'hF;
	end
	task set_sw(input logic [1:0] p);
		sw_pos <= p;
	endtask
	task remote(input logic [1:0] s, input logic [1:0] m);
		req_src <= s;
		req_mode <= m;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		// released lines do not keep their last value
		req_src <= ~s;
		req_mode <= ~m;
	endtask
endmodule // pmrc_src

/* verification/tb.sv */
// self-checking bench for the mode and restart controller
// assumes the source model makes the switch, scans and requests
`timescale 1ns/10ps
`include "pmrc_regs.vh"
module tb;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, s;
	logic [7:0] ad = 0;
	logic [31:0] wd = 0;
	logic cr = 0, cor = 0, sf = 0, ehf = 0, sv = 0, sd = 0, av = 0, aw = 0;
	logic pc = 0, ds = 0, es = 0, ri = 0;
	logic [15:0] sa = 0, aa = 0, ac = 0, v;
	wire [31:0] rdata;
	wire [1:0] sw, rm, rs, mode;
	wire scan, rv, go, halted, ist, icold, keep;
	wire [7:0] trun;
	logic [63:0] q[$];
	logic [63:0] n;
	logic [55:0] chain = 56'h8F7B05DAE5A050;
	logic [3:0] t;
	int seed = 32'ha7da4a95;
	int error_cnt = 0, check_count = 0, i;
	always #5 clk = ~clk;
	pmrc_src pmrc_src_inst (.clk, .rst_n, .sw_pos(sw), .scan_start(scan),
		.req_valid(rv), .req_src(rs), .req_mode(rm));
	pmrc_top pmrc_top_inst (.clk, .rst_n, .reg_addr(ad), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .sw_pos(sw),
		.scan_start(scan), .req_valid(rv), .req_src(rs), .req_mode(rm),
		.cmd_reset(cr), .cmd_overall_reset(cor), .stop_function(sf),
		.emergency_halt_function(ehf), .step_valid(sv), .step_addr(sa),
		.step_done(sd), .acc_valid(av), .acc_write(aw), .acc_addr(aa),
		.acc_data(ac), .program_changed(pc), .download_stop(ds),
		.error_stop(es), .retain_invalid(ri), .mode, .step_go(go),
		.debug_halted(halted), .task_run(trun), .init_start(ist),
		.init_cold(icold), .keep_retain(keep));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		ad <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// a free edge so the next strobe is not set in the same step
		@(posedge clk);
	endtask
	// the read note is queued; the monitor compares it next cycle
	task rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		ad <= a;
		rd <= 1'b1;
		q.push_back({m, e});
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task md(input logic [1:0] m);
		rreg(`PMRC_STATUS_OFS, 32'h3, {30'h0, m});
	endtask
	task sc(input int k);
		repeat (16 * k + 2) @(posedge clk);
	endtask
	task wscan;
		for (int k = 0; k < 20 && scan !== 1'b1; k++)
			@(posedge clk);
		if (scan !== 1'b1) begin
			error_cnt++;
			test_done;
		end
	endtask
	task go_wait(input logic e);
		s = 0;
		repeat (8) begin
			@(posedge clk);
			if (go === 1'b1)
				s = 1;
		end
		chk({31'h0, s}, {31'h0, e});
		if (e && !s)
			test_done;
	endtask
	task acc(input logic [15:0] a, input logic w, input logic [15:0] d);
		av <= 1;
		aw <= w;
		aa <= a;
		ac <= d;
		@(posedge clk);
		av <= 0;
		aa <= ~a;
		repeat (2) @(posedge clk);
	endtask
	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d) begin
			n = q.pop_front();
			chk(rdata & n[63:32], n[31:0]);
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rreg(`PMRC_CTRL_OFS, '1, 32'h0);
		rreg(`PMRC_TASK_EN_OFS, '1, 32'hFF);
		rreg(8'hFC, '1, 32'h0);
		pmrc_src_inst.set_sw(`PMRC_SW_RUN);
		sc(1);
		rreg(`PMRC_STATUS_OFS, 32'h13, 32'h11);
		pmrc_src_inst.remote(0, `PMRC_M_STOP);
		sc(1);
		md(`PMRC_M_RUN);
		pmrc_src_inst.set_sw(`PMRC_SW_REM);
		sc(1);
		md(`PMRC_M_RUN);
		pmrc_src_inst.set_sw(`PMRC_SW_RUN);
		wreg(`PMRC_CTRL_OFS, 32'h2);
		sc(1);
		md(`PMRC_M_RUN);
		pmrc_src_inst.set_sw(`PMRC_SW_REM);
		sc(1);
		md(`PMRC_M_PAUSE);
		pmrc_src_inst.set_sw(`PMRC_SW_STOP);
		sc(1);
		md(`PMRC_M_STOP);
		pmrc_src_inst.set_sw(`PMRC_SW_REM);
		sc(1);
		rreg(`PMRC_STATUS_OFS, 32'hB, 32'h8);
		for (i = 0; i < 14; i++) begin
			t = chain[55 - 4 * i -: 4];
			wreg(`PMRC_STATUS_OFS, 32'h100);
			pmrc_src_inst.remote({1'b0, 1'($random(seed))}, t[3:2]);
			sc(1);
			rreg(`PMRC_STATUS_OFS, 32'h103,
				{23'h0, t[3:2] != t[1:0], 6'h0, t[1:0]});
		end
		for (i = 2; i < 4; i++) begin
			pmrc_src_inst.remote(2'(i), `PMRC_M_RUN);
			sc(1);
			md(`PMRC_M_STOP);
		end
		wreg(`PMRC_CTRL_OFS, 32'h5);
		for (i = 0; i < 5; i++) begin
			case (i)
				1: pc <= 1;
				2: ds <= 1;
				3: es <= 1;
				4: ri <= 1;
			endcase
			@(posedge clk);
			{pc, ds, es} <= 3'h0;
			pmrc_src_inst.remote(2'(2 + i[0]), `PMRC_M_RUN);
			sc(1);
			rreg(`PMRC_STATUS_OFS, 32'h13,
				{27'h0, i != 0, 4'h1});
			chk({31'h0, keep}, {31'h0, i == 0});
			ri <= 0;
			if (i[0])
				ehf <= 1;
			else
				sf <= 1;
			@(posedge clk);
			{sf, ehf} <= 2'h0;
			sc(1);
			md(`PMRC_M_STOP);
		end
		pmrc_src_inst.remote(0, `PMRC_M_RUN);
		sc(1);
		for (i = 0; i < 2; i++) begin
			cr <= !i[0];
			cor <= i[0];
			@(posedge clk);
			{cr, cor} <= 2'h0;
			sc(1);
			rreg(`PMRC_STATUS_OFS, 32'h13, {27'h0, i[0], 4'h1});
			chk({31'h0, keep}, {31'h0, !i[0]});
		end
		pmrc_src_inst.remote(1, `PMRC_M_STOP);
		wreg(`PMRC_CTRL_OFS, 32'h14);
		wreg(`PMRC_TASK_EN_OFS, 32'h5);
		sc(1);
		pmrc_src_inst.remote(0, `PMRC_M_DEBUG);
		sc(1);
		md(`PMRC_M_DEBUG);
		wreg(`PMRC_DBG_CMD_OFS, 32'h1);
		repeat (2) @(posedge clk);
		chk({24'h0, trun}, 32'h5);
		sv <= 1;
		sa <= 16'h0100;
		go_wait(1);
		sv <= 0;
		sd <= 1;
		@(posedge clk);
		sd <= 0;
		sv <= 1;
		go_wait(0);
		rreg(`PMRC_STATUS_OFS, 32'h7, 32'h7);
		sv <= 0;
		wreg(`PMRC_CTRL_OFS, 32'h24);
		for (i = 0; i < 8; i++)
			wreg(8'(`PMRC_BP_BASE_OFS + 4 * i), 32'h80000200 + i);
		wreg(`PMRC_DBG_CMD_OFS, 32'h1);
		sv <= 1;
		sa <= 16'h0207;
		go_wait(0);
		rreg(`PMRC_STATUS_OFS, 32'h7, 32'h7);
		sv <= 0;
		wreg(`PMRC_CTRL_OFS, 32'hC4);
		wreg(`PMRC_SCAN_CNT_OFS, 32'h100);
		wreg(`PMRC_WATCH_ADDR_OFS, 32'h10);
		for (i = 0; i < 3; i++) begin
			v = 16'($random(seed));
			wreg(`PMRC_WATCH_CFG_OFS, {14'h0, 2'(i), v});
			wreg(`PMRC_DBG_CMD_OFS, 32'h1);
			acc(16'h0011, i[0], ~v);
			rreg(`PMRC_STATUS_OFS, 32'h7, 32'h3);
			acc(16'h0010, i[0], v);
			rreg(`PMRC_STATUS_OFS, 32'h7, 32'h7);
		end
		wreg(`PMRC_CTRL_OFS, 32'h84);
		wreg(`PMRC_SCAN_CNT_OFS, 32'h3);
		wscan;
		wreg(`PMRC_DBG_CMD_OFS, 32'h1);
		sc(2);
		rreg(`PMRC_STATUS_OFS, 32'h7, 32'h3);
		sc(1);
		rreg(`PMRC_STATUS_OFS, 32'h7, 32'h7);
		repeat (3) @(posedge clk);
		test_done;
	end
endmodule // tb
bind pmrc_top pmrc_sva pmrc_sva_inst (.clk, .rst_n, .scan_start,
	.stop_function, .emergency_halt_function, .mode, .step_go,
	.debug_halted, .task_run, .init_start, .init_cold, .keep_retain);
